// ===== hdl/adc_cal_pkg.sv
// calibration control package: register offsets, field positions, reset values and codes
// assumes an 8-bit register port behind the serial interface, one byte per address
package adc_cal_pkg;

  // ----------------------------------------------------------------------
  // register port geometry
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned VEC_LEN = 673;  // bytes in one calibration vector

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_RUN_EN   = 8'h61;
  localparam logic [7:0] ADDR_FG_CFG   = 8'h62;
  localparam logic [7:0] ADDR_AVG      = 8'h68;
  localparam logic [7:0] ADDR_STATUS   = 8'h6a;
  localparam logic [7:0] ADDR_PIN_CFG  = 8'h6b;
  localparam logic [7:0] ADDR_SW_TRIG  = 8'h6c;
  localparam logic [7:0] ADDR_VEC_EN   = 8'h70;
  localparam logic [7:0] ADDR_VEC_PORT = 8'h71;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_RUN_EN    = 8'h01;
  localparam logic [7:0] RST_FG_CFG    = 8'h01;
  localparam logic [7:0] RST_AVG       = 8'h61;
  localparam logic [7:0] RST_PIN_CFG   = 8'h00;
  localparam logic [7:0] RST_SW_TRIG   = 8'h01;
  localparam logic [7:0] RST_VEC_EN    = 8'h00;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned RUNEN_BIT     = 0;
  localparam int unsigned FGSEL_BIT     = 0;
  localparam int unsigned AVG_HI_BIT    = 7;
  localparam int unsigned AVG_DEPTH_LSB = 4;
  localparam int unsigned AVG_DEPTH_W   = 3;
  localparam logic [3:0]  AVG_LOW_FIXED = 4'h1;  // low nibble always reads this
  localparam int unsigned STAT_CODE_LSB = 2;
  localparam int unsigned HALTED_BIT    = 1;
  localparam int unsigned FGDONE_BIT    = 0;
  localparam int unsigned PINSEL_LSB    = 1;
  localparam int unsigned TRIGSEL_BIT   = 0;
  localparam int unsigned SWTRIG_BIT    = 0;
  localparam int unsigned VECEN_BIT     = 0;

  // ----------------------------------------------------------------------
  // status pin source codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] PIN_FGDONE = 2'h0;
  localparam logic [1:0] PIN_HALTED = 2'h1;
  localparam logic [1:0] PIN_ALARM  = 2'h2;
  localparam logic [1:0] PIN_LOW    = 2'h3;

  // ----------------------------------------------------------------------
  // calibration status codes and engine states
  // ----------------------------------------------------------------------
  localparam logic [2:0] CODE_HELD    = 3'h0;
  localparam logic [2:0] CODE_WAIT    = 3'h1;
  localparam logic [2:0] CODE_CLEAR   = 3'h2;
  localparam logic [2:0] CODE_FG      = 3'h3;
  localparam logic [2:0] CODE_DONE    = 3'h4;
  localparam logic [2:0] CODE_SKIPPED = 3'h5;

  typedef enum logic [2:0] {CAL_HELD, CAL_WAIT, CAL_CLEAR, CAL_FORE, CAL_DONE, CAL_SKIPPED} cal_state_e;

endpackage

// ===== hdl/cal_vector_mem.sv
// single-port store for the calibration vector, one byte per element
// assumes the caller holds the address one cycle before it samples rdata
`timescale 1ns/100ps
module cal_vector_mem #(
  parameter int unsigned DEPTH = 673,
  parameter int unsigned WIDTH = 8,
  parameter int unsigned AW    = 10
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             we,
  input  wire logic [AW-1:0]    addr,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ----------------------------------------------------------------------
  // storage: no reset on the array, it is meant to map onto a ram
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
  end

  // registered read, old data on a same-cycle write
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= mem[addr];
    end
  end

endmodule

// ===== hdl/adc_calibration_control.sv
// calibration control: configuration and status registers, trigger select,
// status pin source, a simple calibration engine and the vector save/restore port
// assumes a synchronous register port (one strobe per access) and synchronous pins
`timescale 1ns/100ps
module adc_calibration_control #(
  parameter int unsigned VEC_LEN = adc_cal_pkg::VEC_LEN,
  parameter int unsigned DATA_W  = adc_cal_pkg::DATA_W
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic [7:0]        regAddr,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  input  wire logic [7:0]        regWrData,
  output logic      [7:0]        regRdData,
  output logic                   regRdValid,
  input  wire logic              hwCalibTriggerPin,
  input  wire logic              alarmFlag,
  input  wire logic [DATA_W-1:0] offsetSample,
  output logic                   calibStatusPin
);

  localparam int unsigned IDX_W = $clog2(VEC_LEN);
  localparam int unsigned ACC_W = DATA_W + 7;
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(VEC_LEN - 1);

  typedef logic [IDX_W-1:0] idx_t;

  typedef struct packed {
    logic                    runEn;
    logic                    fgSel;
    logic                    avgHi;
    logic [2:0]              avgDepth;
    logic [7:0]              pinCfg;
    logic [7:0]              swTrig;
    logic [7:0]              vecEn;
    adc_cal_pkg::cal_state_e calState;
    idx_t                    engIdx;
    idx_t                    vecIdx;
    logic [ACC_W-1:0]        accum;
    logic [6:0]              dwell;
    logic                    fgDone;
    logic                    halted;
    logic [7:0]              rdData;
    logic                    rdValid;
    logic                    statusPin;
  } state_s;

  state_s s_q;
  state_s s_d;

  logic [DATA_W-1:0] memRdData;
  logic              memWe;
  idx_t              memAddr;
  logic [DATA_W-1:0] memWdata;
  logic              trigger;
  logic              portRd;
  logic              portWr;
  logic              engBusy;
  logic [ACC_W-1:0]  sum;
  logic [6:0]        lastDwell;
  logic [2:0]        statCode;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [2:0] codeOf(input adc_cal_pkg::cal_state_e st);
    unique case (st)
      adc_cal_pkg::CAL_HELD:    codeOf = adc_cal_pkg::CODE_HELD;
      adc_cal_pkg::CAL_WAIT:    codeOf = adc_cal_pkg::CODE_WAIT;
      adc_cal_pkg::CAL_CLEAR:   codeOf = adc_cal_pkg::CODE_CLEAR;
      adc_cal_pkg::CAL_FORE:    codeOf = adc_cal_pkg::CODE_FG;
      adc_cal_pkg::CAL_DONE:    codeOf = adc_cal_pkg::CODE_DONE;
      adc_cal_pkg::CAL_SKIPPED: codeOf = adc_cal_pkg::CODE_SKIPPED;
      default:                  codeOf = adc_cal_pkg::CODE_HELD;
    endcase
  endfunction

  function automatic logic pinOf(input logic [1:0] sel, input logic done, input logic halt, input logic alarm);
    unique case (sel)
      adc_cal_pkg::PIN_FGDONE: pinOf = done;
      adc_cal_pkg::PIN_HALTED: pinOf = halt;
      adc_cal_pkg::PIN_ALARM:  pinOf = alarm;
      default:                 pinOf = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // vector store
  // ----------------------------------------------------------------------
  cal_vector_mem #(
    .DEPTH (VEC_LEN),
    .WIDTH (DATA_W),
    .AW    (IDX_W)
  ) u_vecMem (
    .mclk  (mclk),
    .nrst  (nrst),
    .we    (memWe),
    .addr  (memAddr),
    .wdata (memWdata),
    .rdata (memRdData)
  );

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    s_d       = s_q;
    s_d.rdValid = 1'b0;
    trigger   = s_q.pinCfg[adc_cal_pkg::TRIGSEL_BIT] ? hwCalibTriggerPin
                                                     : s_q.swTrig[adc_cal_pkg::SWTRIG_BIT];
    engBusy   = (s_q.calState == adc_cal_pkg::CAL_CLEAR) || (s_q.calState == adc_cal_pkg::CAL_FORE);
    portRd    = regRdEn && (regAddr == adc_cal_pkg::ADDR_VEC_PORT) && s_q.vecEn[adc_cal_pkg::VECEN_BIT];
    portWr    = regWrEn && (regAddr == adc_cal_pkg::ADDR_VEC_PORT) && s_q.vecEn[adc_cal_pkg::VECEN_BIT];
    sum       = s_q.accum + ACC_W'(offsetSample);
    lastDwell = 7'((8'h01 << s_q.avgDepth) - 8'h01);
    statCode  = codeOf(s_q.calState);
    memWe     = 1'b0;
    memAddr   = engBusy ? s_q.engIdx : s_q.vecIdx;
    memWdata  = regWrData;

    // register writes
    if (regWrEn)
    begin
      unique case (regAddr)
        adc_cal_pkg::ADDR_RUN_EN:  s_d.runEn = regWrData[adc_cal_pkg::RUNEN_BIT];
        adc_cal_pkg::ADDR_FG_CFG:  s_d.fgSel = regWrData[adc_cal_pkg::FGSEL_BIT];
        adc_cal_pkg::ADDR_AVG:
        begin
          s_d.avgHi    = regWrData[adc_cal_pkg::AVG_HI_BIT];
          s_d.avgDepth = regWrData[adc_cal_pkg::AVG_DEPTH_LSB +: adc_cal_pkg::AVG_DEPTH_W];
        end
        adc_cal_pkg::ADDR_PIN_CFG: s_d.pinCfg = regWrData;
        adc_cal_pkg::ADDR_SW_TRIG: s_d.swTrig = regWrData;
        adc_cal_pkg::ADDR_VEC_EN:
        begin
          s_d.vecEn = regWrData;
          if (regWrData[adc_cal_pkg::VECEN_BIT])
            s_d.vecIdx = '0;
        end
        default: ;
      endcase
    end

    // register reads: unmapped addresses answer zero
    if (regRdEn)
    begin
      s_d.rdValid = 1'b1;
      unique case (regAddr)
        adc_cal_pkg::ADDR_RUN_EN:   s_d.rdData = {7'h00, s_q.runEn};
        adc_cal_pkg::ADDR_FG_CFG:   s_d.rdData = {7'h00, s_q.fgSel};
        adc_cal_pkg::ADDR_AVG:      s_d.rdData = {s_q.avgHi, s_q.avgDepth, adc_cal_pkg::AVG_LOW_FIXED};
        adc_cal_pkg::ADDR_STATUS:   s_d.rdData = {3'h0, statCode, s_q.halted, s_q.fgDone};
        adc_cal_pkg::ADDR_PIN_CFG:  s_d.rdData = s_q.pinCfg;
        adc_cal_pkg::ADDR_SW_TRIG:  s_d.rdData = s_q.swTrig;
        adc_cal_pkg::ADDR_VEC_EN:   s_d.rdData = s_q.vecEn;
        adc_cal_pkg::ADDR_VEC_PORT: s_d.rdData = s_q.vecEn[adc_cal_pkg::VECEN_BIT] ? memRdData : 8'h00;
        default:                    s_d.rdData = 8'h00;
      endcase
    end

    // vector port: every access while vecEn bit 0 is set steps the index, wrapping after the last byte
    if (portRd || portWr)
      s_d.vecIdx = (s_q.vecIdx == LAST_IDX) ? '0 : s_q.vecIdx + 1'b1;
    // a port write while the engine owns the store is dropped; software may not do that
    if (portWr && !engBusy)
      memWe = 1'b1;

    // calibration engine
    if (!s_q.runEn)
    begin
      s_d.calState = adc_cal_pkg::CAL_HELD;
      s_d.engIdx   = '0;
      s_d.accum    = '0;
      s_d.dwell    = '0;
      s_d.fgDone   = 1'b0;
      s_d.halted   = 1'b0;
    end
    else
    begin
      unique case (s_q.calState)
        adc_cal_pkg::CAL_HELD: s_d.calState = adc_cal_pkg::CAL_WAIT;
        adc_cal_pkg::CAL_WAIT:
        begin
          if (trigger)
          begin
            s_d.calState = adc_cal_pkg::CAL_CLEAR;
            s_d.engIdx   = '0;
          end
        end
        adc_cal_pkg::CAL_CLEAR:
        begin
          memWe    = 1'b1;
          memWdata = '0;
          if (s_q.engIdx == LAST_IDX)
          begin
            s_d.engIdx = '0;
            s_d.accum  = '0;
            s_d.dwell  = '0;
            if (s_q.fgSel)
            begin
              s_d.calState = adc_cal_pkg::CAL_FORE;
            end
            else
            begin
              s_d.calState = adc_cal_pkg::CAL_SKIPPED;
              s_d.fgDone   = 1'b1;
              s_d.halted   = 1'b1;
            end
          end
          else
          begin
            s_d.engIdx = s_q.engIdx + 1'b1;
          end
        end
        adc_cal_pkg::CAL_FORE:
        begin
          // each element averages 2^depth samples before it is stored
          if (s_q.dwell == lastDwell)
          begin
            memWe     = 1'b1;
            memWdata  = DATA_W'(sum >> s_q.avgDepth);
            s_d.accum = '0;
            s_d.dwell = '0;
            if (s_q.engIdx == LAST_IDX)
            begin
              s_d.calState = adc_cal_pkg::CAL_DONE;
              s_d.fgDone   = 1'b1;
              s_d.halted   = 1'b1;
            end
            else
            begin
              s_d.engIdx = s_q.engIdx + 1'b1;
            end
          end
          else
          begin
            s_d.accum = sum;
            s_d.dwell = s_q.dwell + 1'b1;
          end
        end
        adc_cal_pkg::CAL_DONE, adc_cal_pkg::CAL_SKIPPED: ;
        default: s_d.calState = adc_cal_pkg::CAL_HELD;
      endcase
    end

    // pin follows the flags in the same cycle they are registered
    s_d.statusPin = pinOf(s_q.pinCfg[adc_cal_pkg::PINSEL_LSB +: 2], s_d.fgDone, s_d.halted, alarmFlag);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q           <= '0;
      s_q.runEn     <= adc_cal_pkg::RST_RUN_EN[adc_cal_pkg::RUNEN_BIT];
      s_q.fgSel     <= adc_cal_pkg::RST_FG_CFG[adc_cal_pkg::FGSEL_BIT];
      s_q.avgHi     <= adc_cal_pkg::RST_AVG[adc_cal_pkg::AVG_HI_BIT];
      s_q.avgDepth  <= adc_cal_pkg::RST_AVG[adc_cal_pkg::AVG_DEPTH_LSB +: adc_cal_pkg::AVG_DEPTH_W];
      s_q.pinCfg    <= adc_cal_pkg::RST_PIN_CFG;
      s_q.swTrig    <= adc_cal_pkg::RST_SW_TRIG;
      s_q.vecEn     <= adc_cal_pkg::RST_VEC_EN;
      s_q.calState  <= adc_cal_pkg::CAL_HELD;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign regRdData      = s_q.rdData;
  assign regRdValid     = s_q.rdValid;
  assign calibStatusPin = s_q.statusPin;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence clearEnd;
    s_q.runEn && s_q.calState == adc_cal_pkg::CAL_CLEAR && s_q.engIdx == LAST_IDX;
  endsequence
  sequence fgLastWrite;
    s_q.runEn && s_q.calState == adc_cal_pkg::CAL_FORE && s_q.engIdx == LAST_IDX && s_q.dwell == lastDwell;
  endsequence

  a_avg_readback: assert property (regRdEn && regAddr == adc_cal_pkg::ADDR_AVG |=>
    regRdValid && regRdData[6:4] == $past(s_q.avgDepth) && regRdData[3:0] == 4'h1) else $error("avg readback wrong");
  a_status_code: assert property (regRdEn && regAddr == adc_cal_pkg::ADDR_STATUS |=>
    regRdData[4:2] == $past(statCode) && regRdData[0] == $past(s_q.fgDone)) else $error("status readback wrong");
  a_fg_finish: assert property (fgLastWrite |=>
    s_q.halted && s_q.fgDone && s_q.calState == adc_cal_pkg::CAL_DONE) else $error("flags not set after foreground");
  a_skip_path: assert property (clearEnd ##0 !s_q.fgSel |=>
    s_q.calState == adc_cal_pkg::CAL_SKIPPED && s_q.halted && s_q.fgDone) else $error("skip path flags wrong");
  a_pin_source: assert property (##1 calibStatusPin ==
    pinOf($past(s_q.pinCfg[2:1]), s_q.fgDone, s_q.halted, $past(alarmFlag))) else $error("status pin wrong");
  a_sw_trigger: assert property (s_q.runEn && s_q.calState == adc_cal_pkg::CAL_WAIT &&
    !s_q.pinCfg[0] && s_q.swTrig[0] |=> s_q.calState == adc_cal_pkg::CAL_CLEAR) else $error("sw trigger not taken");
  a_hw_ignored: assert property (s_q.runEn && s_q.calState == adc_cal_pkg::CAL_WAIT &&
    s_q.pinCfg[0] && !hwCalibTriggerPin |=> s_q.calState == adc_cal_pkg::CAL_WAIT) else $error("no hw trigger");
  a_index_restart: assert property (regWrEn && regAddr == adc_cal_pkg::ADDR_VEC_EN && regWrData[0] |=>
    s_q.vecIdx == '0 && s_q.vecEn[0]) else $error("vector index not restarted");
  a_port_step: assert property ((portRd || portWr) && s_q.vecIdx != LAST_IDX |=>
    s_q.vecIdx == $past(s_q.vecIdx) + 1'b1) else $error("vector index did not advance");
  a_port_load: assert property (portWr && !engBusy |-> memWe && memAddr == s_q.vecIdx)
    else $error("vector write not loaded");
  // the second cycle checks only the flags: run enable may already be back high and leave held
  a_held_clear: assert property (!s_q.runEn |=>
    (s_q.calState == adc_cal_pkg::CAL_HELD && !s_q.halted && !s_q.fgDone) ##1 (!s_q.halted && !s_q.fgDone))
    else $error("flags not cleared while held");

endmodule

// ===== sim/tb.sv
// testbench for the calibration control block: register reset values, status, pin source,
// trigger source, vector save/restore and run enable handling
// assumes the design modules from hdl/ are compiled first; vector length reduced to 8
`timescale 1ns/100ps
module tb;
  localparam int unsigned VLEN  = 8;
  localparam int unsigned LIMIT = 20000;  // ceiling in clock cycles, a full run needs under a thousand
  logic       mclk;
  logic       nrst;
  logic [7:0] regAddr;
  logic       regWrEn;
  logic       regRdEn;
  logic [7:0] regWrData;
  logic [7:0] regRdData;
  logic       regRdValid;
  logic       hwCalibTriggerPin;
  logic       alarmFlag;
  logic [7:0] offsetSample;
  logic       calibStatusPin;
  int         err_count;
  int         checks_done;
  int         cycles;
  logic [7:0] rd;

  adc_calibration_control #(.VEC_LEN(VLEN), .DATA_W(8)) uut (
    .mclk(mclk), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .hwCalibTriggerPin(hwCalibTriggerPin), .alarmFlag(alarmFlag), .offsetSample(offsetSample),
    .calibStatusPin(calibStatusPin)
  );

  // ----------------------------------------------------------------------
  // clock, timeout and comparisons
  // ----------------------------------------------------------------------
  // half period of 20 ns gives 25 MHz
  always #20 mclk = ~mclk;

  // a hang is cut short here and reported through the same verdict
  always @(posedge mclk)
  begin
    cycles = cycles + 1;
    if (cycles >= LIMIT)
    begin
      err_count = err_count + 1;
      test_done();
    end
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic checkBit(input logic got, input logic exp);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("BAD t=%0t pin=%h exp=%h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------------
  // register port cycles, driven at the falling edge
  // ----------------------------------------------------------------------
  // an extra idle cycle keeps the two-cycle gap before any vector read
  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(negedge mclk);
    regWrEn = 1'b0;
    @(negedge mclk);
  endtask

  task automatic regRead(input logic [7:0] a, output logic [7:0] d);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge mclk);
    // valid stands for one cycle only, so it is looked at here
    checkBit(regRdValid, 1'b1);
    d = regRdData;
    regRdEn = 1'b0;
    @(negedge mclk);
  endtask

  task automatic readCheck(input logic [7:0] a, input logic [7:0] exp);
    regRead(a, rd);
    checkByte(rd, exp);
  endtask

  // polls status until it matches, bounded by a count of reads
  task automatic waitStatus(input logic [7:0] exp);
    int n;
    n = 0;
    regRead(adc_cal_pkg::ADDR_STATUS, rd);
    while (rd !== exp && n < 3000)
    begin
      regRead(adc_cal_pkg::ADDR_STATUS, rd);
      n = n + 1;
    end
    checkByte(rd, exp);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic resetValues();
    readCheck(adc_cal_pkg::ADDR_AVG, 8'h61);
    readCheck(adc_cal_pkg::ADDR_PIN_CFG, 8'h00);
    readCheck(adc_cal_pkg::ADDR_SW_TRIG, 8'h01);
    readCheck(adc_cal_pkg::ADDR_VEC_EN, 8'h00);
    readCheck(adc_cal_pkg::ADDR_RUN_EN, 8'h01);
    readCheck(adc_cal_pkg::ADDR_FG_CFG, 8'h01);
    readCheck(8'h55, 8'h00);
  endtask

  // automatic run after reset ends in done with both flags high
  task automatic firstRun();
    readCheck(adc_cal_pkg::ADDR_STATUS, {3'h0, adc_cal_pkg::CODE_FG, 2'h0});
    waitStatus({3'h0, adc_cal_pkg::CODE_DONE, 2'h3});
    checkBit(calibStatusPin, 1'b1);
  endtask

  // every pin source code in turn, alarm seen only through code 2
  task automatic pinSources();
    regWrite(adc_cal_pkg::ADDR_PIN_CFG, 8'h02);
    checkBit(calibStatusPin, 1'b1);
    alarmFlag = 1'b1;
    regWrite(adc_cal_pkg::ADDR_PIN_CFG, 8'h04);
    checkBit(calibStatusPin, 1'b1);
    alarmFlag = 1'b0;
    @(negedge mclk);
    @(negedge mclk);
    checkBit(calibStatusPin, 1'b0);
    alarmFlag = 1'b1;
    regWrite(adc_cal_pkg::ADDR_PIN_CFG, 8'h06);
    checkBit(calibStatusPin, 1'b0);
    alarmFlag = 1'b0;
    regWrite(adc_cal_pkg::ADDR_PIN_CFG, 8'h00);
    checkBit(calibStatusPin, 1'b1);
  endtask

  // constant samples average to themselves; then restore a ramp and read it back
  task automatic vectorPort();
    readCheck(adc_cal_pkg::ADDR_STATUS, {3'h0, adc_cal_pkg::CODE_DONE, 2'h3});
    readCheck(adc_cal_pkg::ADDR_VEC_PORT, 8'h00);
    regWrite(adc_cal_pkg::ADDR_VEC_EN, 8'h01);
    for (int i = 0; i < VLEN; i++)
      readCheck(adc_cal_pkg::ADDR_VEC_PORT, 8'h5a);
    regWrite(adc_cal_pkg::ADDR_VEC_EN, 8'h01);
    for (int i = 0; i < VLEN; i++)
      regWrite(adc_cal_pkg::ADDR_VEC_PORT, 8'(i * 17 + 3));
    regWrite(adc_cal_pkg::ADDR_VEC_EN, 8'h01);
    for (int i = 0; i < VLEN; i++)
      readCheck(adc_cal_pkg::ADDR_VEC_PORT, 8'(i * 17 + 3));
    regWrite(adc_cal_pkg::ADDR_VEC_EN, 8'h00);
  endtask

  // run enable, both trigger sources and the skip path
  task automatic triggerRuns();
    regWrite(adc_cal_pkg::ADDR_RUN_EN, 8'h00);
    readCheck(adc_cal_pkg::ADDR_STATUS, 8'h00);
    regWrite(adc_cal_pkg::ADDR_PIN_CFG, 8'h01);
    checkBit(calibStatusPin, 1'b0);
    regWrite(adc_cal_pkg::ADDR_AVG, 8'h8f);
    readCheck(adc_cal_pkg::ADDR_AVG, 8'h81);
    regWrite(adc_cal_pkg::ADDR_RUN_EN, 8'h01);
    readCheck(adc_cal_pkg::ADDR_STATUS, {3'h0, adc_cal_pkg::CODE_WAIT, 2'h0});
    hwCalibTriggerPin = 1'b1;
    waitStatus({3'h0, adc_cal_pkg::CODE_DONE, 2'h3});
    regWrite(adc_cal_pkg::ADDR_RUN_EN, 8'h00);
    regWrite(adc_cal_pkg::ADDR_FG_CFG, 8'h00);
    regWrite(adc_cal_pkg::ADDR_PIN_CFG, 8'h00);
    regWrite(adc_cal_pkg::ADDR_SW_TRIG, 8'h00);
    regWrite(adc_cal_pkg::ADDR_RUN_EN, 8'h01);
    readCheck(adc_cal_pkg::ADDR_STATUS, {3'h0, adc_cal_pkg::CODE_WAIT, 2'h0});
    regWrite(adc_cal_pkg::ADDR_SW_TRIG, 8'h01);
    waitStatus({3'h0, adc_cal_pkg::CODE_SKIPPED, 2'h3});
    checkBit(calibStatusPin, 1'b1);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    nrst = 1'b0;
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regWrData = 8'h00;
    hwCalibTriggerPin = 1'b0;
    alarmFlag = 1'b0;
    offsetSample = 8'h5a;
    err_count = 0;
    checks_done = 0;
    cycles = 0;
    repeat (4) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    resetValues();
    firstRun();
    pinSources();
    vectorPort();
    triggerRuns();
    test_done();
  end
endmodule
